// ### src/vrt_pkg.sv
// Package for the host-side read-transfer and serial-clock controller.
// Assumes one 100 MHz clock; every other rate is derived from it.
package vrt_pkg;

  // ---------------------------------------------------------------
  // Clock and pin timing (ns as printed, then cycle counts)
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;       // System clock period
  localparam int T_RAS_LOW_NS = 100;       // Row strobe low, least
  localparam int T_RAS_HIGH_NS = 80;       // Row strobe precharge, least
  localparam int T_CAS_LOW_NS = 25;        // Column strobe low, least
  localparam int T_RCD_NS = 30;            // Row fall to column fall
  localparam int T_SC_HIGH_NS = 10;        // Shift clock high, least
  localparam int T_SC_CYCLE_NS = 30;       // Shift clock period, least

  // Least times round up, never below one cycle
  localparam int RAS_LOW_CYC = (T_RAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_HIGH_CYC = (T_RAS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_LOW_CYC = (T_CAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SC_HIGH_CYC = (T_SC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SC_CYCLE_CYC = (T_SC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Serial register geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 9;               // Row and column address width
  localparam int HALF_BIT = 8;             // Address bit choosing the half
  localparam logic [7:0] HALF_TOP = 8'hff; // Last bit within a half
  localparam logic [8:0] PTR_RESET = 9'h000;

  // ---------------------------------------------------------------
  // Carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic split;                           // 1: split-register read transfer
    logic [8:0] row;                       // Row to copy
    logic [8:0] tap;                       // Tap point; bit 8 = half
    logic [3:0] load_dly;                  // Extra cycles before gate release
  } vrt_cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ROW = 3'b011,
    ST_COL = 3'b010,
    ST_LOAD = 3'b110,
    ST_PRE = 3'b111
  } vrt_state_e;

endpackage

// ### src/vrt_serial.sv
// Serial shift clock generator and model of the device's serial pointer.
// Assumes the owner blocks shift requests while a transfer is running.
module vrt_serial (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Shift request and transfer completion
  input wire logic shift_req,
  input wire logic inhibit,
  input wire logic load_normal,
  input wire logic load_split,
  input wire logic [8:0] load_tap,
  // Pin and model state
  output logic sc,
  output logic sc_rise,
  output logic sc_done,
  output logic [8:0] ptr,
  output logic split_mode,
  output logic half
);

  // -------------------------------------------------------------
  // Shift clock phase
  // -------------------------------------------------------------
  logic [3:0] phase;                     // Cycles left in this SC period
  logic pend;                            // Tap waiting for inactive half
  logic [8:0] pend_tap;                  // That waiting tap
  wire start = shift_req && !inhibit && (phase == 4'h0);
  wire at_top = split_mode && (ptr[7:0] == vrt_pkg::HALF_TOP);
  wire [8:0] jump_ptr = pend ? pend_tap : {~ptr[8], 8'h00};
  wire [8:0] next_ptr = at_top ? jump_ptr : 9'(ptr + 9'h001);

  // SC high for the least high time, period one cycle longer than the least cycle time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 4'h0;
      sc <= 1'b0;
    end else if (start) begin
      phase <= 4'(vrt_pkg::SC_CYCLE_CYC);
      sc <= 1'b1;
    end else begin
      if (phase != 4'h0) phase <= phase - 4'h1;
      if (phase == 4'(vrt_pkg::SC_CYCLE_CYC - vrt_pkg::SC_HIGH_CYC + 1)) sc <= 1'b0;
    end
  end

  // Edge and period-end pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sc_rise <= 1'b0;
      sc_done <= 1'b0;
    end else begin
      sc_rise <= start;
      sc_done <= (phase == 4'h1);
    end
  end

  // -------------------------------------------------------------
  // Pointer model
  // -------------------------------------------------------------
  // Normal transfers reload, split ones arm the tap; each SC rise steps, wraps or jumps halves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= vrt_pkg::PTR_RESET;
      split_mode <= 1'b0;
      pend <= 1'b0;
      pend_tap <= vrt_pkg::PTR_RESET;
    end else if (load_normal) begin
      ptr <= load_tap;
      split_mode <= 1'b0;
      pend <= 1'b0;
    end else if (load_split) begin
      split_mode <= 1'b1;
      pend <= 1'b1;
      pend_tap <= load_tap;
    end else if (start) begin
      ptr <= next_ptr;
      if (at_top) pend <= 1'b0;
    end
  end

  // Half flag follows the pointer top bit
  assign half = ptr[vrt_pkg::HALF_BIT];

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  property p_wrap;
    @(posedge clk) disable iff (!rst_b)
      start && !split_mode && (ptr == 9'h1ff) |=> (ptr == 9'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Pointer did not wrap to 0");

  property p_half_jump;
    @(posedge clk) disable iff (!rst_b)
      start && at_top && !pend |=> (ptr[7:0] == 8'h00) && (ptr[8] != $past(ptr[8]));
  endproperty
  a_half_jump: assert property (p_half_jump) else $error("Pointer missed half start");

  property p_tap_jump;
    @(posedge clk) disable iff (!rst_b)
      start && at_top && pend |=> (ptr == $past(pend_tap));
  endproperty
  a_tap_jump: assert property (p_tap_jump) else $error("Pointer missed pending tap");

endmodule

// ### src/vrt_host.sv
// Host controller issuing normal and split read transfers to a video
// memory and clocking its serial port. Inputs are synchronous to CLK.
module vrt_host (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Transfer command port
  input wire logic CMD_VALID,
  input wire vrt_pkg::vrt_cmd_s CMD,
  output logic CMD_READY,
  output logic CMD_REFUSED,
  // Serial read port
  input wire logic SHIFT_REQ,
  output logic [3:0] SER_DATA,
  output logic SER_VALID,
  output logic HALF_MISMATCH,
  // Memory pins
  output logic RAS_N,
  output logic CAS_N,
  output logic TRANSFER_GATE_N,
  output logic WRITE_N,
  output logic SERIAL_ENABLE_N,
  output logic SPECIAL_FUNCTION_SELECT,
  output logic [8:0] ADDR,
  output logic SERIAL_SHIFT_CLOCK,
  input wire logic [3:0] SERIAL_DATA_LINES,
  input wire logic SPLIT_HALF_INDICATOR
);

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  vrt_pkg::vrt_state_e state;            // Transfer sequencer state
  vrt_pkg::vrt_state_e next_state;
  vrt_pkg::vrt_cmd_s cur;                // Accepted command
  logic [7:0] cnt;                       // Cycle counter within a state
  logic normal_done;                     // A normal read has completed
  logic sc_seen;                         // SC rose since last split
  logic load_normal;                     // Transfer completion pulses
  logic load_split;
  logic sc_rise;
  logic sc_done;
  logic [8:0] ptr;
  logic split_mode;
  logic half;

  // -------------------------------------------------------------
  // Command check
  // -------------------------------------------------------------
  wire bad_tap = CMD.split && (CMD.tap[7:0] == vrt_pkg::HALF_TOP);
  wire no_base = CMD.split && !normal_done;
  wire no_edge = CMD.split && split_mode && !sc_seen;
  wire take = CMD_VALID && CMD_READY;
  wire legal = !(bad_tap || no_base || no_edge);
  wire cnt_end = (cnt == 8'h00);

  // Next state of the transfer sequencer
  always_comb begin
    next_state = state;
    case (state)
      vrt_pkg::ST_IDLE: if (take && legal) next_state = vrt_pkg::ST_SETUP;
      vrt_pkg::ST_SETUP: next_state = vrt_pkg::ST_ROW;
      vrt_pkg::ST_ROW: if (cnt_end) next_state = vrt_pkg::ST_COL;
      vrt_pkg::ST_COL: if (cnt_end) next_state = vrt_pkg::ST_LOAD;
      vrt_pkg::ST_LOAD: if (cnt_end) next_state = vrt_pkg::ST_PRE;
      vrt_pkg::ST_PRE: if (cnt_end) next_state = vrt_pkg::ST_IDLE;
      default: next_state = vrt_pkg::ST_IDLE;
    endcase
  end

  // Sequencer, command hold and counter
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= vrt_pkg::ST_IDLE;
      cur <= '0;
      cnt <= 8'h00;
    end else begin
      state <= next_state;
      if (take) cur <= CMD;
      if (next_state != state) begin
        case (next_state)
          vrt_pkg::ST_ROW: cnt <= 8'(vrt_pkg::RCD_CYC - 1);
          vrt_pkg::ST_COL: cnt <= 8'(vrt_pkg::RAS_LOW_CYC - vrt_pkg::RCD_CYC - 1);
          vrt_pkg::ST_LOAD: cnt <= {4'h0, cur.load_dly};
          vrt_pkg::ST_PRE: cnt <= 8'(vrt_pkg::RAS_HIGH_CYC - 1);
          default: cnt <= 8'h00;
        endcase
      end else if (!cnt_end) begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  // -------------------------------------------------------------
  // Pin drive
  // -------------------------------------------------------------
  // Gate and select set a cycle before row fall; write and serial
  // enable stay high and low, so only read-type transfers occur
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RAS_N <= 1'b1;
      CAS_N <= 1'b1;
      TRANSFER_GATE_N <= 1'b1;
      WRITE_N <= 1'b1;
      SERIAL_ENABLE_N <= 1'b1;
      SPECIAL_FUNCTION_SELECT <= 1'b0;
      ADDR <= 9'h000;
    end else begin
      WRITE_N <= 1'b1;
      SERIAL_ENABLE_N <= 1'b0;
      case (next_state)
        vrt_pkg::ST_SETUP: begin
          TRANSFER_GATE_N <= 1'b0;
          SPECIAL_FUNCTION_SELECT <= CMD.split;
          ADDR <= CMD.row;
        end
        vrt_pkg::ST_ROW: RAS_N <= 1'b0;
        vrt_pkg::ST_COL: begin
          CAS_N <= 1'b0;
          ADDR <= cur.tap;
        end
        vrt_pkg::ST_PRE: begin
          TRANSFER_GATE_N <= 1'b1;
          RAS_N <= 1'b1;
          CAS_N <= 1'b1;
        end
        default: SPECIAL_FUNCTION_SELECT <= SPECIAL_FUNCTION_SELECT;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Sequence bookkeeping and handshake
  // -------------------------------------------------------------
  wire finish = (state == vrt_pkg::ST_LOAD) && cnt_end;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CMD_READY <= 1'b0;
      CMD_REFUSED <= 1'b0;
      normal_done <= 1'b0;
      sc_seen <= 1'b0;
      load_normal <= 1'b0;
      load_split <= 1'b0;
    end else begin
      CMD_READY <= (next_state == vrt_pkg::ST_IDLE) && !(take && legal);
      CMD_REFUSED <= take && !legal;
      load_normal <= finish && !cur.split;
      load_split <= finish && cur.split;
      if (finish && !cur.split) normal_done <= 1'b1;
      // An SC edge in the finishing cycle still counts
      if (sc_rise) sc_seen <= 1'b1;
      else if (finish && cur.split) sc_seen <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // Serial port
  // -------------------------------------------------------------
  vrt_serial u_serial (
    .clk(CLK),
    .rst_b(RST_B),
    .shift_req(SHIFT_REQ),
    .inhibit(state != vrt_pkg::ST_IDLE),
    .load_normal(load_normal),
    .load_split(load_split),
    .load_tap(cur.tap),
    .sc(SERIAL_SHIFT_CLOCK),
    .sc_rise(sc_rise),
    .sc_done(sc_done),
    .ptr(ptr),
    .split_mode(split_mode),
    .half(half)
  );

  // Data sampled at end of SC period; half checked at the same edge
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SER_DATA <= 4'h0;
      SER_VALID <= 1'b0;
      HALF_MISMATCH <= 1'b0;
    end else begin
      SER_VALID <= sc_done;
      if (sc_done) SER_DATA <= SERIAL_DATA_LINES;
      HALF_MISMATCH <= sc_done && (SPLIT_HALF_INDICATOR != half);
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  sequence s_gate_first;
    !TRANSFER_GATE_N && RAS_N ##1 !TRANSFER_GATE_N && !RAS_N;
  endsequence

  property p_gate_first;
    @(posedge CLK) disable iff (!RST_B) $fell(RAS_N) |-> $past(!TRANSFER_GATE_N) && !TRANSFER_GATE_N;
  endproperty
  a_gate_first: assert property (p_gate_first) else $error("Row fell without gate low");

  property p_read_type;
    @(posedge CLK) disable iff (!RST_B) $fell(RAS_N) |-> WRITE_N;
  endproperty
  a_read_type: assert property (p_read_type) else $error("Write strobe low at row fall");

  property p_split_select;
    @(posedge CLK) disable iff (!RST_B) s_gate_first |-> (SPECIAL_FUNCTION_SELECT == cur.split);
  endproperty
  a_split_select: assert property (p_split_select) else $error("Select wrong at row fall");

  property p_row_width;
    @(posedge CLK) disable iff (!RST_B) $fell(RAS_N) |-> !RAS_N [*8] ##1 !RAS_N [*2];
  endproperty
  a_row_width: assert property (p_row_width) else $error("Row strobe low too short");

  property p_tap_ok;
    @(posedge CLK) disable iff (!RST_B) $fell(CAS_N) && SPECIAL_FUNCTION_SELECT |-> ADDR[7:0] != 8'hff;
  endproperty
  a_tap_ok: assert property (p_tap_ok) else $error("Split tap at half top");

  property p_base_first;
    @(posedge CLK) disable iff (!RST_B) $fell(RAS_N) && SPECIAL_FUNCTION_SELECT |-> normal_done;
  endproperty
  a_base_first: assert property (p_base_first) else $error("Split before any normal read");

  property p_quiet;
    @(posedge CLK) disable iff (!RST_B) !RAS_N |-> !sc_rise;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Shift during transfer");

  property p_ras_from_cmd;
    @(posedge CLK) disable iff (!RST_B) take && legal |-> ##2 $fell(RAS_N) ##3 $fell(CAS_N);
  endproperty
  a_ras_from_cmd: assert property (p_ras_from_cmd) else $error("Strobe timing off");

endmodule

// ### sim/vrt_mem_model.sv
// Behavioural video memory: read transfers, serial pointer, half flag.
// Assumes the host drives the strobes; bad_half is set by the bench only.
module vrt_mem_model (
  // Strobes and address
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic trg_n,
  input wire logic we_n,
  input wire logic se_n,
  input wire logic sfs,
  input wire logic [8:0] addr,
  // Serial port
  input wire logic sc,
  output logic [3:0] serial_data_lines,
  output logic split_half_indicator,
  // Fault control and protocol flag
  input wire logic bad_half,
  output logic rule_err
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [8:0] row_lo, row_hi, ptr, lat_row, lat_tap, arm_tap; // Halves, pointer, latches
  logic xfer, split, arm, smode, out_mode, nrm_done, sc_seen; // Cycle and mode flags
  logic [3:0] sdq_q; // Last nibble shown
  initial begin
    {xfer, split, arm, smode, out_mode, nrm_done, sc_seen, rule_err} = '0;
    {row_lo, row_hi, ptr, lat_row, lat_tap, arm_tap, sdq_q} = '0;
  end
  // ----------------------------------------
  // Transfer decode on row fall
  // ----------------------------------------
  always @(negedge ras_n) begin
    xfer = !trg_n;
    split = xfer && we_n && sfs;
    lat_row = addr;
    if (xfer && !we_n && se_n) out_mode = 1'b0;
    if (split && (!nrm_done || !sc_seen)) rule_err = 1'b1; // Host broke split order
  end
  // Tap latch on column fall
  always @(negedge cas_n) begin
    if (xfer) lat_tap = addr;
    if (split && addr[7:0] == 8'hff) rule_err = 1'b1; // Forbidden split tap
  end
  // Load at gate release
  always @(posedge trg_n) begin
    if (xfer && we_n && !split) begin
      row_lo = lat_row;
      row_hi = lat_row;
      ptr = lat_tap;
      {arm, smode, nrm_done, sc_seen} = 4'b0111;
    end else if (split) begin
      if (lat_tap[8]) row_hi = lat_row;
      else row_lo = lat_row;
      arm_tap = lat_tap;
      {arm, sc_seen} = 2'b10;
    end
    if (xfer && we_n) out_mode = 1'b1;
    xfer = 1'b0;
  end
  // ----------------------------------------
  // Serial clock: show nibble, step pointer
  // ----------------------------------------
  always @(posedge sc) begin
    if (!ras_n && xfer) rule_err = 1'b1;
    sdq_q = (ptr[8] ? row_hi[3:0] : row_lo[3:0]) ^ ptr[3:0];
    sc_seen = 1'b1;
    if (smode && ptr[7:0] == 8'hff) begin
      ptr = (arm && arm_tap[8] != ptr[8]) ? arm_tap : {~ptr[8], 8'h00};
      arm = 1'b0;
    end else begin
      ptr = ptr + 9'h001;
    end
  end
  // Undriven lines show the inverse of the last nibble
  assign serial_data_lines = (out_mode && !se_n) ? sdq_q : ~sdq_q;
  assign split_half_indicator = ptr[8] ^ bad_half;
endmodule

// ### sim/tb_vrt_host.sv
// Self-checking bench for the read-transfer host controller.
// Assumes vrt_pkg and the memory model are compiled first.
module tb_vrt_host;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic CLK, RST_B, CMD_VALID, SHIFT_REQ, bad_half, rule_err; // Bench drives, and the model's rule_err
  vrt_pkg::vrt_cmd_s CMD; // Command carrier
  logic CMD_READY, CMD_REFUSED, SER_VALID, HALF_MISMATCH, RAS_N, CAS_N, TRANSFER_GATE_N; // Host outputs
  logic WRITE_N, SERIAL_ENABLE_N, SPECIAL_FUNCTION_SELECT, SERIAL_SHIFT_CLOCK, SPLIT_HALF_INDICATOR;
  logic [3:0] SER_DATA, SERIAL_DATA_LINES; // Nibbles
  logic [8:0] ADDR; // Row and tap
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  vrt_host DUT (.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
    .CMD_REFUSED(CMD_REFUSED), .SHIFT_REQ(SHIFT_REQ), .SER_DATA(SER_DATA), .SER_VALID(SER_VALID),
    .HALF_MISMATCH(HALF_MISMATCH), .RAS_N(RAS_N), .CAS_N(CAS_N), .TRANSFER_GATE_N(TRANSFER_GATE_N),
    .WRITE_N(WRITE_N), .SERIAL_ENABLE_N(SERIAL_ENABLE_N), .SPECIAL_FUNCTION_SELECT(SPECIAL_FUNCTION_SELECT),
    .ADDR(ADDR), .SERIAL_SHIFT_CLOCK(SERIAL_SHIFT_CLOCK), .SERIAL_DATA_LINES(SERIAL_DATA_LINES),
    .SPLIT_HALF_INDICATOR(SPLIT_HALF_INDICATOR));
  vrt_mem_model mem (.ras_n(RAS_N), .cas_n(CAS_N), .trg_n(TRANSFER_GATE_N), .we_n(WRITE_N),
    .se_n(SERIAL_ENABLE_N), .sfs(SPECIAL_FUNCTION_SELECT), .addr(ADDR), .sc(SERIAL_SHIFT_CLOCK),
    .serial_data_lines(SERIAL_DATA_LINES), .split_half_indicator(SPLIT_HALF_INDICATOR), .bad_half(bad_half), .rule_err(rule_err));
  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Present one command; judge refusal or ready return time
  task automatic cmd(input logic sp, input logic [8:0] row, input logic [8:0] tap, input logic [3:0] d,
                     input logic refuse);
    int n;
    logic rdy;
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD <= '{split: sp, row: row, tap: tap, load_dly: d};
    rdy = 1'b0;
    n = 0;
    // Ready read settled, before the edge that takes the command
    while (rdy !== 1'b1 && n < 100) begin
      #1;
      rdy = CMD_READY;
      @(posedge CLK);
      n++;
    end
    CMD_VALID <= 1'b0;
    // Refusal pulse stands only in the cycle after the take
    #1;
    check("cmd_refused", CMD_REFUSED, refuse);
    @(posedge CLK);
    #1;
    n = 1;
    while (!refuse && CMD_READY !== 1'b1 && n < 80) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (!refuse) check("ready_time", n[8:0], 9'(20 + d));
  endtask
  // One serial clock; judge nibble, latency and half flag
  task automatic shift(input logic [8:0] row, input logic [8:0] a, input logic bad);
    int n;
    @(posedge CLK);
    SHIFT_REQ <= 1'b1;
    @(posedge CLK);
    SHIFT_REQ <= 1'b0;
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (SER_VALID !== 1'b1 && n < 10);
    check("ser_latency", n[8:0], 9'h004);
    check("ser_data", {5'h00, SER_DATA}, {5'h00, row[3:0] ^ a[3:0]});
    check("half_mismatch", HALF_MISMATCH, bad);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Pins idle in reset; ready one edge after release
  task automatic t_reset();
    repeat (6) @(posedge CLK);
    #1;
    check("reset_pins", {RAS_N, CAS_N, TRANSFER_GATE_N, SERIAL_SHIFT_CLOCK, CMD_READY}, 9'h01c);
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    #1;
    check("ready_after_reset", CMD_READY, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_order();
    cmd(1'b1, 9'h001, 9'h000, 4'h0, 1'b1);
    cmd(1'b0, 9'h005, 9'h1fd, 4'h0, 1'b0);
    for (int i = 0; i < 5; i++) shift(9'h005, 9'(9'h1fd + i), 1'b0);
    cmd(1'b1, 9'h004, 9'h0ff, 4'h0, 1'b1);
    cmd(1'b1, 9'h004, 9'h1ff, 4'h0, 1'b1);
    $display("test order_wrap_taps done");
  endtask
  task automatic t_split();
    logic [8:0] a;
    cmd(1'b0, 9'h002, 9'h0fc, 4'h2, 1'b0);
    cmd(1'b1, 9'h007, 9'h110, 4'h0, 1'b0);
    cmd(1'b1, 9'h006, 9'h020, 4'h0, 1'b1);
    a = 9'h0fc;
    for (int i = 0; i < 246; i++) begin
      shift(a[8] ? 9'h007 : 9'h002, a, 1'b0);
      a = (a == 9'h0ff) ? 9'h110 : a + 9'h001;
    end
    $display("test split_jump done");
  endtask
  task automatic t_overlap();
    cmd(1'b0, 9'h003, 9'h000, 4'hf, 1'b0);
    @(posedge CLK);
    SHIFT_REQ <= 1'b1;
    cmd(1'b0, 9'h008, 9'h040, 4'h3, 1'b0);
    @(posedge CLK);
    SHIFT_REQ <= 1'b0;
    repeat (8) @(posedge CLK);
    cmd(1'b0, 9'h001, 9'h100, 4'h0, 1'b0);
    bad_half <= 1'b1;
    shift(9'h001, 9'h100, 1'b1);
    bad_half <= 1'b0;
    shift(9'h001, 9'h101, 1'b0);
    #1;
    check("model_protocol", rule_err, 1'b0);
    $display("test overlap_half done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    RST_B = 1'b0;
    CMD_VALID = 1'b0;
    SHIFT_REQ = 1'b0;
    bad_half = 1'b0;
    CMD = '0;
    t_reset();
    t_order();
    t_split();
    t_overlap();
    print_verdict();
  end
endmodule
